//--- verilog/rfcw_pkg.sv
package rfcw_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ARG = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_RXSEQ = 8'h10;
   localparam logic [7:0] OFS_ERR = 8'h14;

   // ----------------------------------------
   // Command codes written to the command register
   // ----------------------------------------
   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_ACK = 4'h1;
   localparam logic [3:0] CMD_NEGATIVE_ACKNOWLEDGE_WORD = 4'h2;
   localparam logic [3:0] CMD_FULL = 4'h3;
   localparam logic [3:0] CMD_SDF = 4'h4;
   localparam logic [3:0] CMD_SBF = 4'h5;
   localparam logic [3:0] CMD_SIF = 4'h6;
   localparam logic [3:0] CMD_EDF = 4'h7;
   localparam logic [3:0] CMD_EBF = 4'h8;
   localparam logic [3:0] CMD_TOKEN = 4'h9;
   localparam logic [3:0] CMD_FLUSH = 4'hA;
   localparam logic [3:0] CMD_DATA = 4'hF;

   // ----------------------------------------
   // Symbol values (data byte of each code)
   // ----------------------------------------
   localparam logic [7:0] K28_7 = 8'hFC;
   localparam logic [7:0] K28_0 = 8'h1C;
   localparam logic [7:0] K28_2 = 8'h5C;
   localparam logic [7:0] D2_5 = 8'hA2;
   localparam logic [7:0] D27_5 = 8'hBB;
   localparam logic [7:0] D15_3 = 8'h6F;
   localparam logic [7:0] D7_4 = 8'h87;
   localparam logic [7:0] D16_2 = 8'h50;
   localparam logic [7:0] D29_2 = 8'h5D;
   localparam logic [7:0] D4_2 = 8'h44;
   localparam logic [7:0] D0_0 = 8'h00;
   localparam logic [3:0] KF_CTRL = 4'h1;
   localparam logic [3:0] KF_DATA = 4'h0;

   // ----------------------------------------
   // Reset and start values
   // ----------------------------------------
   localparam logic [6:0] SEQ_CNT_RST = 7'h00;
   localparam logic SEQ_POL_RST = 1'b0;
   localparam logic [7:0] CRC8_INIT = 8'h00;
   localparam logic [15:0] CRC16_INIT = 16'hFFFF;
   localparam logic [7:0] ERR_CNT_MAX = 8'hFF;

endpackage

//--- verilog/crc_step.sv
`timescale 1ns/1ns
// ----------------------------------------
// One combinational CRC update over a word
// ----------------------------------------
module crc_step #(
   parameter int W = 8,
   parameter int DW = 24,
   parameter logic [W-1:0] POLY = '0
) (
   input wire logic [W-1:0] crc_in,
   input wire logic [DW-1:0] data,
   output logic [W-1:0] crc_out
);

   // Bit-serial form, least significant bit first, as symbols go out
   always_comb
   begin
      logic [W-1:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = 0; i < DW; i++)
      begin
         fb = c[W-1] ^ data[i];
         c = {c[W-2:0], 1'b0};
         if (fb)
         begin
            c = c ^ POLY;
         end
      end
      crc_out = c;
   end

endmodule

//--- verilog/retry_framing_control_words.sv
`timescale 1ns/1ns
module retry_framing_control_words
   import rfcw_pkg::*;
#(
   parameter logic [7:0] CRC8_POLY = 8'h07,
   parameter logic [15:0] CRC16_POLY = 16'h1021
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk,
   input wire logic [31:0] rx_word,
   input wire logic [3:0] rx_kflag,
   output logic [31:0] tx_word,
   output logic [3:0] tx_kflag,
   output logic tx_valid,
   output logic retry_request,
   output logic replay_start
);

   // ----------------------------------------
   // Link clock sampling
   // ----------------------------------------
   logic lclk_s1_r, lclk_s2_r, lclk_s3_r;
   wire link_tick = lclk_s2_r & ~lclk_s3_r;

   // Three stages; the edge is judged only on the later two
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lclk_s1_r <= 1'b0;
         lclk_s2_r <= 1'b0;
         lclk_s3_r <= 1'b0;
      end
      else
      begin
         lclk_s1_r <= link_clk;
         lclk_s2_r <= lclk_s1_r;
         lclk_s3_r <= lclk_s2_r;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [16:0] arg_r;
   logic pend_r;
   logic [3:0] pend_cmd_r;
   logic [31:0] pend_data_r;
   logic [6:0] seq_cnt_r;
   logic seq_pol_r;
   logic [15:0] frame_crc_r;
   logic [7:0] bcast_crc_r;
   logic retry_pend_r;
   logic negative_acknowledge_word_seen_r, full_seen_r;
   logic [7:0] ack_seq_r, negative_acknowledge_word_seq_r;
   logic [7:0] err_cnt_r;
   logic [31:0] rx_word_r;
   logic [3:0] rx_k_r;
   logic rx_vld_r;
   logic [31:0] tx_word_r;
   logic [3:0] tx_k_r;
   logic tx_valid_r, replay_start_r;

   // ----------------------------------------
   // Register bus decode
   // ----------------------------------------
   wire apb_acc = psel & penable;
   wire hit_cmd = paddr == OFS_CMD;
   wire hit_arg = paddr == OFS_ARG;
   wire hit_data = paddr == OFS_DATA;
   wire hit_stat = paddr == OFS_STAT;
   wire hit_rxseq = paddr == OFS_RXSEQ;
   wire hit_err = paddr == OFS_ERR;
   wire addr_ok = hit_cmd | hit_arg | hit_data | hit_stat | hit_rxseq | hit_err;
   // One-deep queue: a word write waits while the previous word is unsent
   wire queue_wr = pwrite & (hit_cmd | hit_data);
   assign pready = ~(apb_acc & queue_wr & pend_r);
   assign pslverr = apb_acc & ~addr_ok;
   wire apb_done = apb_acc & pready & addr_ok;
   wire wr_cmd = apb_done & pwrite & hit_cmd;
   wire wr_data = apb_done & pwrite & hit_data;
   wire wr_arg = apb_done & pwrite & hit_arg;
   wire wr_stat = apb_done & pwrite & hit_stat;

   // Read mux; reserved bits read zero
   wire [7:0] cur_seq = {seq_pol_r, seq_cnt_r};
   assign prdata = hit_cmd ? {27'h0000000, pend_r, pend_cmd_r} :
                   hit_arg ? {15'h0000, arg_r} :
                   hit_stat ? {20'h00000, retry_pend_r, full_seen_r, negative_acknowledge_word_seen_r, 1'b0,
                               cur_seq} :
                   hit_rxseq ? {16'h0000, negative_acknowledge_word_seq_r, ack_seq_r} :
                   hit_err ? {24'h000000, err_cnt_r} : 32'h00000000;

   // ----------------------------------------
   // Transmit word assembly
   // ----------------------------------------
   wire [7:0] arg_lo = arg_r[7:0];
   wire [7:0] arg_hi = arg_r[15:8];
   wire [7:0] late_sym = {7'h00, arg_r[16]};
   wire [7:0] seq_next = {seq_pol_r, 7'(seq_cnt_r + 7'h01)};
   wire do_retry = link_tick & retry_pend_r;
   wire do_cmd = link_tick & ~retry_pend_r & pend_r;
   wire is_sdf = pend_cmd_r == CMD_SDF;
   wire is_sbf = pend_cmd_r == CMD_SBF;
   wire is_edf = pend_cmd_r == CMD_EDF;
   wire is_ebf = pend_cmd_r == CMD_EBF;
   wire is_data = pend_cmd_r == CMD_DATA;
   wire [31:0] sdf_word = {D0_0, arg_lo, D16_2, K28_7};
   wire [31:0] sbf_word = {arg_hi, arg_lo, D29_2, K28_7};
   wire [31:0] edf_part = {16'h0000, seq_next, K28_0};
   wire [31:0] ebf_part = {8'h00, seq_next, late_sym, K28_2};

   // Frame CRCs span the start word, data and end word less its CRC bytes
   wire [15:0] fc_in = is_sdf ? CRC16_INIT : frame_crc_r;
   wire [31:0] fc_data = is_edf ? edf_part : (is_sdf ? sdf_word : pend_data_r);
   wire [7:0] bc_in = is_sbf ? CRC8_INIT : bcast_crc_r;
   wire [31:0] bc_data = is_ebf ? ebf_part : (is_sbf ? sbf_word : pend_data_r);
   logic [15:0] fc_out;
   logic [7:0] bc_out;
   logic [7:0] ctl_crc;
   logic [23:0] ctl_body;

   crc_step #(.W(16), .DW(32), .POLY(CRC16_POLY)) u_frame_crc (
      .crc_in(fc_in),
      .data(fc_data),
      .crc_out(fc_out)
   );

   crc_step #(.W(8), .DW(32), .POLY(CRC8_POLY)) u_bcast_crc (
      .crc_in(bc_in),
      .data(bc_data),
      .crc_out(bc_out)
   );

   // Control word CRC covers the three symbols before it, comma data included
   crc_step #(.W(8), .DW(24), .POLY(CRC8_POLY)) u_ctl_crc (
      .crc_in(CRC8_INIT),
      .data(ctl_body),
      .crc_out(ctl_crc)
   );

   // Word for the queued command
   logic [31:0] cmd_word;
   logic [3:0] cmd_k;
   logic cmd_emit;
   always_comb
   begin
      ctl_body = 24'h000000;
      cmd_word = 32'h00000000;
      cmd_k = KF_CTRL;
      cmd_emit = 1'b1;
      case (pend_cmd_r)
         CMD_ACK:
         begin
            ctl_body = {arg_lo, D2_5, K28_7};
            cmd_word = {ctl_crc, ctl_body};
         end
         CMD_NEGATIVE_ACKNOWLEDGE_WORD:
         begin
            ctl_body = {arg_lo, D27_5, K28_7};
            cmd_word = {ctl_crc, ctl_body};
         end
         CMD_FULL:
         begin
            ctl_body = {cur_seq, D15_3, K28_7};
            cmd_word = {ctl_crc, ctl_body};
         end
         CMD_SDF: cmd_word = sdf_word;
         CMD_SBF: cmd_word = sbf_word;
         CMD_SIF:
         begin
            ctl_body = {cur_seq, D4_2, K28_7};
            cmd_word = {ctl_crc, ctl_body};
         end
         CMD_EDF: cmd_word = {fc_out, seq_next, K28_0};
         CMD_EBF: cmd_word = {bc_out, seq_next, late_sym, K28_2};
         CMD_DATA:
         begin
            cmd_word = pend_data_r;
            cmd_k = KF_DATA;
         end
         default: cmd_emit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Receive word checking
   // ----------------------------------------
   logic [7:0] rx_crc;
   crc_step #(.W(8), .DW(24), .POLY(CRC8_POLY)) u_rx_crc (
      .crc_in(CRC8_INIT),
      .data(rx_word_r[23:0]),
      .crc_out(rx_crc)
   );
   wire rx_comma = rx_vld_r & (rx_k_r == KF_CTRL) & (rx_word_r[7:0] == K28_7);
   wire rx_crc_ok = rx_crc == rx_word_r[31:24];
   wire rx_is_ack = rx_comma & (rx_word_r[15:8] == D2_5);
   wire rx_is_negative_acknowledge_word = rx_comma & (rx_word_r[15:8] == D27_5);
   wire rx_is_full = rx_comma & (rx_word_r[15:8] == D15_3);
   wire rx_checked = rx_is_ack | rx_is_negative_acknowledge_word | rx_is_full;
   wire rx_bad = rx_checked & ~rx_crc_ok;
   wire ack_ok = rx_is_ack & rx_crc_ok;
   wire negative_acknowledge_word_ok = rx_is_negative_acknowledge_word & rx_crc_ok;
   wire full_ok = rx_is_full & rx_crc_ok;

   // Receive capture at the link edge; word stable for half a link period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_word_r <= 32'h00000000;
         rx_k_r <= KF_DATA;
         rx_vld_r <= 1'b0;
      end
      else
      begin
         rx_vld_r <= link_tick;
         if (link_tick)
         begin
            rx_word_r <= rx_word;
            rx_k_r <= rx_kflag;
         end
      end
   end

   // Received status; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         negative_acknowledge_word_seen_r <= 1'b0;
         full_seen_r <= 1'b0;
         ack_seq_r <= 8'h00;
         negative_acknowledge_word_seq_r <= 8'h00;
         err_cnt_r <= 8'h00;
      end
      else
      begin
         negative_acknowledge_word_seen_r <= negative_acknowledge_word_ok | (negative_acknowledge_word_seen_r & ~(wr_stat & pwdata[9]));
         full_seen_r <= full_ok | (full_seen_r & ~(wr_stat & pwdata[10]));
         if (ack_ok)
            ack_seq_r <= rx_word_r[23:16];
         if (negative_acknowledge_word_ok)
            negative_acknowledge_word_seq_r <= rx_word_r[23:16];
         if (rx_bad && err_cnt_r != ERR_CNT_MAX)
            err_cnt_r <= err_cnt_r + 8'h01;
      end
   end

   // ----------------------------------------
   // Command queue and argument register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         arg_r <= 17'h00000;
         pend_r <= 1'b0;
         pend_cmd_r <= CMD_NONE;
         pend_data_r <= 32'h00000000;
      end
      else
      begin
         if (wr_arg)
            arg_r <= pwdata[16:0];
         if (wr_cmd)
         begin
            pend_r <= 1'b1;
            pend_cmd_r <= pwdata[3:0];
         end
         else if (wr_data)
         begin
            pend_r <= 1'b1;
            pend_cmd_r <= CMD_DATA;
            pend_data_r <= pwdata;
         end
         else if (do_cmd)
            pend_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Link-wide sequence number and retry
   // ----------------------------------------
   // Single counter for every channel, so no per-channel copies exist
   wire seq_bump = do_cmd & (is_edf | is_ebf | (pend_cmd_r == CMD_TOKEN));
   wire flush = do_cmd & (pend_cmd_r == CMD_FLUSH);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_cnt_r <= SEQ_CNT_RST;
         seq_pol_r <= SEQ_POL_RST;
         retry_pend_r <= 1'b0;
         frame_crc_r <= CRC16_INIT;
         bcast_crc_r <= CRC8_INIT;
      end
      else
      begin
         if (do_retry)
         begin
            // Replayed frames renumber from the last one the far end took
            seq_pol_r <= ~seq_pol_r;
            seq_cnt_r <= negative_acknowledge_word_seq_r[6:0];
         end
         else if (flush)
         begin
            seq_cnt_r <= SEQ_CNT_RST;
            seq_pol_r <= SEQ_POL_RST;
         end
         else if (seq_bump)
            seq_cnt_r <= 7'(seq_cnt_r + 7'h01);
         // Set wins: a second negative acknowledge keeps the retry pending
         retry_pend_r <= negative_acknowledge_word_ok | (retry_pend_r & ~do_retry);
         if (do_cmd && (is_sdf || is_data || is_edf))
            frame_crc_r <= fc_out;
         if (do_cmd && (is_sbf || is_data || is_ebf))
            bcast_crc_r <= bc_out;
      end
   end

   // ----------------------------------------
   // Transmit output register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_word_r <= 32'h00000000;
         tx_k_r <= KF_DATA;
         tx_valid_r <= 1'b0;
         replay_start_r <= 1'b0;
      end
      else
      begin
         replay_start_r <= do_retry;
         if (do_retry)
         begin
            tx_word_r <= {D0_0, D0_0, D7_4, K28_7};
            tx_k_r <= KF_CTRL;
            tx_valid_r <= 1'b1;
         end
         else if (do_cmd)
         begin
            tx_word_r <= cmd_word;
            tx_k_r <= cmd_k;
            tx_valid_r <= cmd_emit;
         end
         else if (link_tick)
            tx_valid_r <= 1'b0;
      end
   end

   assign tx_word = tx_word_r;
   assign tx_kflag = tx_k_r;
   assign tx_valid = tx_valid_r;
   assign retry_request = retry_pend_r;
   assign replay_start = replay_start_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_ack_layout;
      @(posedge pclk) disable iff (!presetn)
      do_cmd && pend_cmd_r == CMD_ACK |=>
         tx_word_r[7:0] == K28_7 && tx_word_r[15:8] == D2_5 && tx_k_r == KF_CTRL
         && tx_word_r[23:16] == $past(arg_lo);
   endproperty
   a_ack_layout: assert property (p_ack_layout) else $error("ack layout wrong");

   property p_retry_word;
      @(posedge pclk) disable iff (!presetn)
      do_retry |=> tx_word_r == {D0_0, D0_0, D7_4, K28_7} && tx_valid_r && replay_start_r
         ##1 !replay_start_r;
   endproperty
   a_retry_word: assert property (p_retry_word) else $error("retry word wrong");

   property p_pol_toggle;
      @(posedge pclk) disable iff (!presetn)
      do_retry |=> seq_pol_r != $past(seq_pol_r) && !retry_pend_r;
   endproperty
   a_pol_toggle: assert property (p_pol_toggle) else $error("polarity not toggled");

   property p_seq_incr;
      @(posedge pclk) disable iff (!presetn)
      do_cmd && (is_edf || is_ebf) |=> seq_cnt_r == 7'($past(seq_cnt_r) + 7'h01)
         && ($past(is_edf) ? tx_word_r[15:8] : tx_word_r[23:16]) == cur_seq;
   endproperty
   a_seq_incr: assert property (p_seq_incr) else $error("sequence not advanced");

   property p_flush_clear;
      @(posedge pclk) disable iff (!presetn)
      flush && !do_retry |=> seq_cnt_r == SEQ_CNT_RST && seq_pol_r == SEQ_POL_RST;
   endproperty
   a_flush_clear: assert property (p_flush_clear) else $error("flush left sequence");

   property p_full_seq;
      @(posedge pclk) disable iff (!presetn)
      do_cmd && pend_cmd_r == CMD_FULL |=> tx_word_r[23:16] == $past(cur_seq)
         && tx_word_r[15:8] == D15_3;
   endproperty
   a_full_seq: assert property (p_full_seq) else $error("full word sequence wrong");

   property p_bad_crc_ignored;
      @(posedge pclk) disable iff (!presetn)
      rx_bad && !retry_pend_r |=> !retry_pend_r && $stable(negative_acknowledge_word_seq_r) && $stable(ack_seq_r);
   endproperty
   a_bad_crc_ignored: assert property (p_bad_crc_ignored) else $error("bad word acted on");

   property p_negative_acknowledge_word_retry;
      @(posedge pclk) disable iff (!presetn)
      negative_acknowledge_word_ok |=> retry_pend_r && negative_acknowledge_word_seq_r == $past(rx_word_r[23:16]);
   endproperty
   a_negative_acknowledge_word_retry: assert property (p_negative_acknowledge_word_retry) else $error("negative ack not taken");

   property p_edf_layout;
      @(posedge pclk) disable iff (!presetn)
      do_cmd && is_edf |=> tx_word_r[7:0] == K28_0 && tx_word_r[31:16] == frame_crc_r;
   endproperty
   a_edf_layout: assert property (p_edf_layout) else $error("data end word wrong");

   property p_stall;
      @(posedge pclk) disable iff (!presetn)
      apb_acc && queue_wr && pend_r |-> !pready ##1 $stable(pend_cmd_r);
   endproperty
   a_stall: assert property (p_stall) else $error("queued word overwritten");

endmodule

//--- verif/link_peer.sv
`timescale 1ns/1ns
// ----------
// Far link end: free running link clock and word source
// ----------
module link_peer #(
   parameter logic [7:0] CRC8_POLY = 8'h07
) (
   output logic link_clk,
   output logic [31:0] rx_word,
   output logic [3:0] rx_kflag
);
   logic [31:0] next_w;
   logic next_v;
   logic [31:0] fill_w;

   // Control CRC over the three leading symbols, fed LSB first
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < 24; i++)
      begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
      end
      return c;
   endfunction

   // Comma first, type, sequence, then CRC on top
   function automatic logic [31:0] cw(input logic [7:0] t, input logic [7:0] s);
      return {crc8({s, t, 8'hFC}), s, t, 8'hFC};
   endfunction

   // Clock runs free at eight pclk periods; the 7 ns offset keeps its edges off the pclk edges
   initial
   begin
      link_clk = 1'b0;
      next_v = 1'b0;
      next_w = 32'h0;
      fill_w = 32'h0;
      rx_word = 32'h0;
      rx_kflag = 4'h0;
      #7;
      forever #40 link_clk = ~link_clk;
   end

   // Words change at the falling edge, stable at the rising one
   always @(negedge link_clk)
   begin
      if (next_v)
      begin
         rx_word <= next_w;
         rx_kflag <= 4'h1;
         next_v <= 1'b0;
      end
      else
      begin
         fill_w <= fill_w + 32'h0101_0101;
         rx_word <= ~fill_w; // Filler never repeats the last word
         rx_kflag <= 4'h0;
      end
   end

   task automatic send(input logic [31:0] w);
      next_w = w;
      next_v = 1'b1;
   endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb
   import rfcw_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, tx_word, rx_word, q;
   logic [3:0] tx_kflag, rx_kflag;
   logic tx_valid, retry_request, replay_start, link_clk;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;

   retry_framing_control_words #(.CRC8_POLY(8'h07), .CRC16_POLY(16'h1021)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_clk(link_clk), .rx_word(rx_word), .rx_kflag(rx_kflag), .tx_word(tx_word),
      .tx_kflag(tx_kflag), .tx_valid(tx_valid), .retry_request(retry_request),
      .replay_start(replay_start));
   link_peer #(.CRC8_POLY(8'h07)) peer (.link_clk(link_clk), .rx_word(rx_word),
      .rx_kflag(rx_kflag));

   // ----------
   // Clock, hang guard, reporting
   // ----------
   always #5 pclk = ~pclk;

   // Whole run needs under fifteen hundred cycles
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Reference frame CRCs, whole words fed bit-serially, LSB first
   function automatic logic [15:0] crc16w(input logic [15:0] c0, input logic [31:0] d);
      logic [15:0] c;
      c = c0;
      for (int i = 0; i < 32; i++)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction

   function automatic logic [7:0] crc8w(input logic [7:0] c0, input logic [31:0] d);
      logic [7:0] c;
      c = c0;
      for (int i = 0; i < 32; i++)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   // ----------
   // Bus cycles and word sending
   // ----------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // Waits for the queued word to leave; tx then holds a link period
   task automatic send(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      do
         rd(OFS_CMD);
      while (q[4] !== 1'b0);
      repeat (2) @(posedge pclk);
   endtask

   task automatic cmd(input logic [3:0] c);
      send(OFS_CMD, {28'h0, c});
   endtask

   task automatic word(input logic [31:0] exp);
      chk(tx_word, exp);
      chk({28'h0, tx_kflag}, {28'h0, KF_CTRL});
      chk({31'h0, tx_valid}, 32'h1);
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_reset();
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h0);
      rd(8'h18);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_words();
      apb(1'b1, OFS_ARG, 32'h12);
      cmd(CMD_ACK);
      word(peer.cw(D2_5, 8'h12));
      apb(1'b1, OFS_ARG, 32'h34);
      cmd(CMD_NEGATIVE_ACKNOWLEDGE_WORD);
      word(peer.cw(D27_5, 8'h34));
      apb(1'b1, OFS_ARG, 32'h0907);
      cmd(CMD_SDF);
      word({D0_0, 8'h07, D16_2, K28_7});
      cmd(CMD_SBF);
      word({8'h09, 8'h07, D29_2, K28_7});
      cmd(CMD_FULL);
      word(peer.cw(D15_3, 8'h00));
      cmd(CMD_SIF);
      word(peer.cw(D4_2, 8'h00));
      $display("test words done");
   endtask

   task automatic t_frames();
      logic [15:0] f;
      logic [7:0] b;
      // CRC bytes of the end word count as zero while folding it in
      f = crc16w(16'hFFFF, {D0_0, 8'h01, D16_2, K28_7});
      f = crc16w(f, 32'hA5A5_0F0F);
      f = crc16w(f, {16'h0, 8'h01, K28_0});
      b = crc8w(8'h00, {8'h00, 8'h01, D29_2, K28_7});
      b = crc8w(b, {8'h00, 8'h02, 8'h01, K28_2});
      apb(1'b1, OFS_ARG, 32'h0001_0001);
      cmd(CMD_SDF);
      send(OFS_DATA, 32'hA5A5_0F0F);
      chk(tx_word, 32'hA5A5_0F0F);
      chk({28'h0, tx_kflag}, {28'h0, KF_DATA});
      chk({31'h0, tx_valid}, 32'h1);
      cmd(CMD_EDF);
      chk({16'h0, tx_word[15:0]}, {16'h0, 8'h01, K28_0});
      chk(tx_word, {f, 8'h01, K28_0});
      cmd(CMD_SBF);
      cmd(CMD_EBF);
      chk({8'h0, tx_word[23:0]}, {8'h0, 8'h02, 8'h01, K28_2});
      chk(tx_word, {b, 8'h02, 8'h01, K28_2});
      cmd(CMD_TOKEN);
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h03);
      $display("test frames done");
   endtask

   task automatic t_retry();
      logic bad;
      peer.send(peer.cw(D27_5, 8'h05));
      while (retry_request !== 1'b1)
         @(posedge pclk);
      while (replay_start !== 1'b1)
         @(posedge pclk);
      chk(tx_word, {D0_0, D0_0, D7_4, K28_7});
      rd(OFS_STAT);
      chk({23'h0, q[9], q[7:0]}, 32'h185);
      rd(OFS_RXSEQ);
      chk({24'h0, q[15:8]}, 32'h05);
      cmd(CMD_FULL);
      word(peer.cw(D15_3, 8'h85));
      peer.send(peer.cw(D27_5, 8'h10) ^ 32'h0100_0000);
      bad = 1'b0;
      repeat (40)
      begin
         @(posedge pclk);
         if (retry_request === 1'b1)
            bad = 1'b1;
      end
      chk({31'h0, bad}, 32'h0);
      rd(OFS_ERR);
      chk({24'h0, q[7:0]}, 32'h01);
      peer.send(peer.cw(D2_5, 8'h23));
      repeat (40) @(posedge pclk);
      rd(OFS_RXSEQ);
      chk({24'h0, q[7:0]}, 32'h23);
      $display("test retry done");
   endtask

   // Full wrap of the count; polarity must not move
   task automatic t_flush();
      cmd(CMD_FLUSH);
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h00);
      repeat (127) cmd(CMD_TOKEN);
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h7F);
      cmd(CMD_TOKEN);
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h00);
      // Back-to-back writes: the second and third must wait on the busy queue
      repeat (3) apb(1'b1, OFS_CMD, {28'h0, CMD_TOKEN});
      send(OFS_CMD, {28'h0, CMD_NONE});
      rd(OFS_STAT);
      chk({24'h0, q[7:0]}, 32'h03);
      $display("test flush done");
   endtask

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_words();
      t_frames();
      t_retry();
      t_flush();
      print_verdict();
   end
endmodule
